// ==== nand_front_regs.svh ====
// constants of the serial nand command front end: opcodes, feature
// addresses, field positions, reset values and cache limits.
// assumes inclusion by bare name from the design module and the bench.
`ifndef NAND_FRONT_REGS_SVH
`define NAND_FRONT_REGS_SVH

// opcodes
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_GET_FEAT 8'h0f
`define OP_SET_FEAT 8'h1f
`define OP_PAGE_READ 8'h13
`define OP_RD_CACHE 8'h03
`define OP_RD_CACHE_F 8'h0b
`define OP_RD_CACHE_X2 8'h3b
`define OP_RD_CACHE_X4 8'h6b
`define OP_RD_CACHE_DIO 8'hbb
`define OP_RD_CACHE_QIO 8'heb
`define OP_READ_ID 8'h9f
`define OP_READ_UID 8'h4b
`define OP_LOAD 8'h02
`define OP_LOAD_X4 8'h32
`define OP_RLOAD 8'h84
`define OP_RLOAD_X4 8'hc4
`define OP_RLOAD_X4B 8'h34
`define OP_RLOAD_QIO 8'h72
`define OP_PROG_EXEC 8'h10
`define OP_BLK_ERASE 8'hd8
`define OP_RESET 8'hff
`define OP_BLK_LOCK 8'h36
`define OP_BLK_UNLOCK 8'h39
`define OP_BLK_QUERY 8'h3d
`define OP_LOCK_ALL 8'h7e
`define OP_UNLOCK_ALL 8'h98

// feature addresses
`define FEAT_LOCK 8'ha0
`define FEAT_CONF 8'hb0
`define FEAT_STAT 8'hc0

// lock register layout and reset values
`define LOCK_GUARD_BIT 7
`define LOCK_RST 8'h00
`define QUAD_RST 1'b0

// cache column limits and block address mask
`define CACHE_BYTES 12'd2112
`define WRAP_2112_LAST 12'd2111
`define WRAP_2048_LAST 12'd2047
`define BLOCK_ADDR_MASK 24'h7ff000

`endif

// ==== nand_front_pkg.sv ====
// types of the serial nand command front end.
// assumes the constants header is on the include path.
package nand_front_pkg;

	// command phase, one per field of the serial frame, and ST_IGNORE for the rest of it
	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_ADDR,
		ST_DUMMY,
		ST_DIN,
		ST_DOUT,
		ST_IGNORE
	} phase_t;

	// layout of one command after its opcode
	typedef struct packed {
		logic [5:0] addr_bits;
		logic [2:0] lines_a;
		logic [5:0] dummy_bits;
		logic [2:0] lines_d;
		logic din;
		logic dout;
		logic quad;
		logic move;
		logic legal;
	} plan_t;

endpackage

// ==== nand_front_end.sv ====
// serial command front end of a serial nand flash: pin sampling, pause,
// command decode, field packing, feature bits and the write latch.
// assumes serial pins arrive asynchronously and are oversampled by
// sys_clk_in at many times the serial clock rate; the array core sits
// on the user ports and answers read data combinationally from col_out.
`timescale 1ns/1ns
`include "nand_front_regs.svh"

module nand_front_end #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'h3c // arbitrary value
) (
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic io_line_0_in,
	input wire logic io_line_1_in,
	input wire logic io_line_2_in,
	input wire logic io_line_3_in,
	output logic io_line_0_out,
	output logic io_line_1_out,
	output logic io_line_2_out,
	output logic io_line_3_out,
	output logic io_line_0_oe_out,
	output logic io_line_1_oe_out,
	output logic io_line_2_oe_out,
	output logic io_line_3_oe_out,
	input wire logic [7:0] rd_data_in,
	input wire logic [7:0] lock_status_in,
	input wire logic [5:0] status_hi_in,
	input wire logic busy_in,
	input wire logic op_done_in,
	input wire logic move_active_in,
	input wire logic [63:0] uid_in,
	output logic cmd_valid_out,
	output logic [7:0] cmd_opcode_out,
	output logic [23:0] cmd_addr_out,
	output logic wr_data_valid_out,
	output logic [7:0] wr_data_out,
	output logic [11:0] col_out,
	output logic write_latch_out,
	output logic [7:0] lock_reg_out,
	output logic quad_lines_on_out
);

	// two-flop synchronisers; stage one is read only by stage two
	logic [5:0] sync1; // {sclk, cs, io3..io0}
	logic [5:0] sync2;
	logic sclk_d; // delayed sclk for edge finding
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sync1 <= 6'h10;
			sync2 <= 6'h10;
			sclk_d <= 1'b0;
		end else begin
			sync1 <= {sclk_in, cs_n_in, io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in};
			sync2 <= sync1;
			sclk_d <= sync2[5];
		end
	end

	logic sclk_s, cs_hi, hold_s, wp_s;
	logic [3:0] d_s; // sampled data lines
	assign sclk_s = sync2[5];
	assign cs_hi = sync2[4];
	assign d_s = sync2[3:0];
	assign hold_s = sync2[3]; // pause pin shares line 3
	assign wp_s = sync2[2]; // guard pin shares line 2

	// one command layout
	function automatic nand_front_pkg::plan_t mk(input logic [5:0] ab, input logic [2:0] la,
		input logic [5:0] db, input logic [2:0] ld, input logic di, input logic dq,
		input logic q, input logic m);
		mk = '{ab, la, db, ld, di, dq, q, m, 1'b1};
	endfunction

	// opcode decode into field layout
	function automatic nand_front_pkg::plan_t decode(input logic [7:0] op);
		decode = '0;
		unique case (op)
			`OP_SET_LATCH, `OP_CLR_LATCH, `OP_RESET, `OP_LOCK_ALL, `OP_UNLOCK_ALL:
				decode = mk(6'd0, 3'd1, 6'd0, 3'd1, 1'b0, 1'b0, 1'b0, 1'b0);
			`OP_GET_FEAT: decode = mk(6'd8, 3'd1, 6'd0, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_SET_FEAT: decode = mk(6'd8, 3'd1, 6'd0, 3'd1, 1'b1, 1'b0, 1'b0, 1'b0);
			`OP_PAGE_READ, `OP_PROG_EXEC, `OP_BLK_ERASE, `OP_BLK_LOCK, `OP_BLK_UNLOCK:
				decode = mk(6'd24, 3'd1, 6'd0, 3'd1, 1'b0, 1'b0, 1'b0, 1'b0);
			`OP_BLK_QUERY: decode = mk(6'd24, 3'd1, 6'd0, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_RD_CACHE, `OP_RD_CACHE_F:
				decode = mk(6'd16, 3'd1, 6'd8, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_RD_CACHE_X2: decode = mk(6'd16, 3'd1, 6'd8, 3'd2, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_RD_CACHE_X4: decode = mk(6'd16, 3'd1, 6'd8, 3'd4, 1'b0, 1'b1, 1'b1, 1'b0);
			`OP_RD_CACHE_DIO: decode = mk(6'd16, 3'd2, 6'd8, 3'd2, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_RD_CACHE_QIO: decode = mk(6'd16, 3'd4, 6'd8, 3'd4, 1'b0, 1'b1, 1'b1, 1'b0);
			`OP_LOAD: decode = mk(6'd16, 3'd1, 6'd0, 3'd1, 1'b1, 1'b0, 1'b0, 1'b0);
			`OP_LOAD_X4: decode = mk(6'd16, 3'd1, 6'd0, 3'd4, 1'b1, 1'b0, 1'b1, 1'b0);
			`OP_RLOAD: decode = mk(6'd16, 3'd1, 6'd0, 3'd1, 1'b1, 1'b0, 1'b0, 1'b1);
			`OP_RLOAD_X4, `OP_RLOAD_X4B:
				decode = mk(6'd16, 3'd1, 6'd0, 3'd4, 1'b1, 1'b0, 1'b1, 1'b1);
			`OP_RLOAD_QIO: decode = mk(6'd16, 3'd4, 6'd0, 3'd4, 1'b1, 1'b0, 1'b1, 1'b1);
			`OP_READ_ID: decode = mk(6'd0, 3'd1, 6'd8, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0);
			`OP_READ_UID: decode = mk(6'd0, 3'd1, 6'd32, 3'd1, 1'b0, 1'b1, 1'b0, 1'b0);
			default: decode = '0; // unknown opcode: frame is ignored
		endcase
	endfunction

	// shift n lines into the low end, line n-1 as the earlier bit
	function automatic logic [23:0] shift_in(input logic [23:0] sr, input logic [2:0] n,
		input logic [3:0] d);
		unique case (n)
			3'd2: shift_in = {sr[21:0], d[1:0]};
			3'd4: shift_in = {sr[19:0], d};
			default: shift_in = {sr[22:0], d[0]};
		endcase
	endfunction

	// next column inside the chosen wrap window
	function automatic logic [11:0] wrap_step(input logic [11:0] c, input logic [3:0] w);
		unique case (w[3:2])
			2'b00: wrap_step = (c == `WRAP_2112_LAST) ? 12'h000 : c + 12'h001;
			2'b01: wrap_step = (c == `WRAP_2048_LAST) ? 12'h000 : c + 12'h001;
			2'b10: wrap_step = {c[11:6], c[5:0] + 6'h01};
			default: wrap_step = {c[11:4], c[3:0] + 4'h1};
		endcase
	endfunction

	// frame state
	nand_front_pkg::phase_t st, next_st;
	nand_front_pkg::plan_t plan, next_plan;
	logic paused, next_paused;
	logic [5:0] field_cnt, next_field_cnt; // bits taken in this field
	logic [23:0] in_sr, next_in_sr;
	logic [7:0] opcode, next_opcode;
	logic [7:0] feat_addr, next_feat_addr;
	logic [3:0] wrap, next_wrap;
	logic [7:0] out_sr, next_out_sr;
	logic [3:0] out_pos, next_out_pos; // bits already sent of this byte
	logic [2:0] byte_idx, next_byte_idx;
	logic [3:0] io_o, next_io_o, io_oe, next_io_oe;
	logic next_cmd_valid, next_wr_valid, next_latch, next_quad;
	logic [7:0] next_cmd_op, next_wr_data, next_lock;
	logic [23:0] next_cmd_addr;
	logic [11:0] next_col;

	// helpers visible to the checks below
	logic rise, fall, go, resume_ev, pause_now, op_fin, feat_wr, guard_blk;
	logic [7:0] op_byte, cur_byte, bits;
	logic [5:0] got;
	logic [2:0] ln;
	logic [23:0] sr_n;
	nand_front_pkg::plan_t dec;
	assign rise = sclk_s & ~sclk_d;
	assign fall = ~sclk_s & sclk_d;
	assign resume_ev = fall & hold_s;
	// outside quad mode, a falling edge that finds the pause pin low starts the pause and
	// shifts nothing, so the held bit is the first one out on resume
	assign pause_now = ~paused & ~hold_s & ~sclk_s & ~quad_lines_on_out;
	// paused frames act again only on the releasing falling edge
	assign go = ~cs_hi & ((~paused & ~pause_now) | resume_ev);
	// in quad mode the guard pin is a data line and protects nothing
	assign guard_blk = lock_reg_out[`LOCK_GUARD_BIT] & ~wp_s & ~quad_lines_on_out;

	// outgoing byte source for the current command
	always_comb begin
		unique case (opcode)
			`OP_READ_ID: cur_byte = byte_idx[0] ? PART_CODE : MAKER_CODE;
			`OP_READ_UID: cur_byte = uid_in[{3'd7 - byte_idx, 3'b000} +: 8];
			`OP_BLK_QUERY: cur_byte = lock_status_in;
			`OP_GET_FEAT: begin
				unique case (feat_addr)
					`FEAT_LOCK: cur_byte = lock_reg_out;
					`FEAT_CONF: cur_byte = {7'h00, quad_lines_on_out};
					`FEAT_STAT: cur_byte = {status_hi_in, write_latch_out, busy_in};
					default: cur_byte = 8'h00;
				endcase
			end
			default: cur_byte = rd_data_in; // cache reads
		endcase
	end

	// next-state logic of the serial frame
	always_comb begin
		next_st = st;
		next_plan = plan;
		next_field_cnt = field_cnt;
		next_in_sr = in_sr;
		next_opcode = opcode;
		next_feat_addr = feat_addr;
		next_wrap = wrap;
		next_out_sr = out_sr;
		next_out_pos = out_pos;
		next_byte_idx = byte_idx;
		next_io_o = io_o;
		next_io_oe = io_oe;
		next_cmd_valid = 1'b0;
		next_cmd_op = cmd_opcode_out;
		next_cmd_addr = cmd_addr_out;
		next_wr_valid = 1'b0;
		next_wr_data = wr_data_out;
		next_col = col_out;
		next_latch = write_latch_out;
		next_quad = quad_lines_on_out;
		next_lock = lock_reg_out;
		next_paused = paused;
		op_fin = 1'b0;
		feat_wr = 1'b0;
		ln = (st == nand_front_pkg::ST_OPCODE) ? 3'd1 :
			(st == nand_front_pkg::ST_ADDR || st == nand_front_pkg::ST_DUMMY) ?
			plan.lines_a : plan.lines_d;
		got = field_cnt + 6'(ln);
		sr_n = shift_in(in_sr, ln, d_s);
		op_byte = sr_n[7:0];
		dec = decode(op_byte);
		bits = (out_pos == 4'd0) ? cur_byte : out_sr;
		// completion of program or erase drops the latch; a set below wins
		if (op_done_in) begin
			next_latch = 1'b0;
		end
		if (cs_hi) begin
			// release ends the frame and drops any partial byte
			next_st = nand_front_pkg::ST_OPCODE;
			next_field_cnt = 6'd0;
			next_out_pos = 4'd0;
			next_byte_idx = 3'd0;
			next_io_oe = 4'h0;
			next_paused = 1'b0;
		end else if (go && rise) begin
			next_in_sr = sr_n;
			next_field_cnt = got;
			unique case (st)
				nand_front_pkg::ST_OPCODE: if (got == 6'd8) begin
					op_fin = 1'b1;
					next_opcode = op_byte;
					next_plan = dec;
					next_field_cnt = 6'd0;
					if (op_byte == `OP_CLR_LATCH) begin
						next_latch = 1'b0;
					end
					if (op_byte == `OP_SET_LATCH) begin
						next_latch = 1'b1;
					end
					if (!dec.legal || (dec.quad && !quad_lines_on_out) ||
						(dec.move && !move_active_in)) begin
						next_st = nand_front_pkg::ST_IGNORE;
					end else if (dec.addr_bits != 6'd0) begin
						next_st = nand_front_pkg::ST_ADDR;
					end else begin
						next_cmd_valid = 1'b1;
						next_cmd_op = op_byte;
						next_cmd_addr = 24'h000000;
						next_st = (dec.dummy_bits != 6'd0) ? nand_front_pkg::ST_DUMMY :
							nand_front_pkg::ST_IGNORE;
					end
				end
				nand_front_pkg::ST_ADDR: if (got == plan.addr_bits) begin
					next_field_cnt = 6'd0;
					next_feat_addr = sr_n[7:0];
					next_wrap = sr_n[15:12];
					next_col = sr_n[11:0];
					next_cmd_op = opcode;
					next_cmd_addr = (opcode == `OP_BLK_LOCK || opcode == `OP_BLK_UNLOCK ||
						opcode == `OP_BLK_QUERY) ? (sr_n & `BLOCK_ADDR_MASK) : sr_n;
					next_cmd_valid = ((opcode != `OP_PROG_EXEC) && (opcode != `OP_BLK_ERASE)) ||
						write_latch_out;
					next_st = (plan.dummy_bits != 6'd0) ? nand_front_pkg::ST_DUMMY :
						plan.din ? nand_front_pkg::ST_DIN :
						plan.dout ? nand_front_pkg::ST_DOUT : nand_front_pkg::ST_IGNORE;
				end
				nand_front_pkg::ST_DUMMY: if (got == plan.dummy_bits) begin
					next_field_cnt = 6'd0;
					next_st = nand_front_pkg::ST_DOUT;
				end
				nand_front_pkg::ST_DIN: if (got == 6'd8) begin
					next_field_cnt = 6'd0;
					if (opcode == `OP_SET_FEAT) begin
						feat_wr = 1'b1;
						next_st = nand_front_pkg::ST_IGNORE;
						if (feat_addr == `FEAT_LOCK) begin
							// reserved bits 6 and 0 are forced low
							next_lock = guard_blk ?
								{sr_n[7], 1'b0, lock_reg_out[5:1], 1'b0} :
								{sr_n[7], 1'b0, sr_n[5:1], 1'b0};
						end else if (feat_addr == `FEAT_CONF) begin
							next_quad = sr_n[0];
						end
					end else begin
						// bytes past the cache end are dropped
						next_wr_valid = (col_out < `CACHE_BYTES);
						next_wr_data = sr_n[7:0];
						next_col = (col_out < `CACHE_BYTES) ? col_out + 12'h001 : col_out;
					end
				end
				nand_front_pkg::ST_DOUT, nand_front_pkg::ST_IGNORE: begin
					next_field_cnt = field_cnt;
				end
				default: next_st = nand_front_pkg::ST_IGNORE;
			endcase
		end else if (go && fall && st == nand_front_pkg::ST_DOUT) begin
			// msb first; dual puts the earlier bit on line 1
			unique case (plan.lines_d)
				3'd2: begin
					next_io_o = {2'b00, bits[7:6]};
					next_io_oe = 4'h3;
				end
				3'd4: begin
					next_io_o = bits[7:4];
					next_io_oe = 4'hf;
				end
				default: begin
					next_io_o = {2'b00, bits[7], 1'b0};
					next_io_oe = 4'h2;
				end
			endcase
			next_out_sr = bits << plan.lines_d;
			next_out_pos = out_pos + 4'(plan.lines_d);
			if (out_pos + 4'(plan.lines_d) == 4'd8) begin
				next_out_pos = 4'd0;
				next_byte_idx = byte_idx + 3'd1;
				next_col = wrap_step(col_out, wrap);
			end
		end
		// pause: enter when the pin is low and the clock is low, not in quad mode; no bit
		// is lost because the entering edge is blocked above
		if (!cs_hi && pause_now) begin
			next_paused = 1'b1;
		end
		if (!cs_hi && paused && resume_ev) begin
			next_paused = 1'b0;
		end
		if (next_paused) begin
			next_io_oe = 4'h0;
		end
	end

	// registers of the frame
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			st <= nand_front_pkg::ST_OPCODE;
			plan <= '0;
			paused <= 1'b0;
			field_cnt <= 6'd0;
			in_sr <= 24'h000000;
			opcode <= 8'h00;
			feat_addr <= 8'h00;
			wrap <= 4'h0;
			out_sr <= 8'h00;
			out_pos <= 4'd0;
			byte_idx <= 3'd0;
			io_o <= 4'h0;
			io_oe <= 4'h0;
			cmd_valid_out <= 1'b0;
			cmd_opcode_out <= 8'h00;
			cmd_addr_out <= 24'h000000;
			wr_data_valid_out <= 1'b0;
			wr_data_out <= 8'h00;
			col_out <= 12'h000;
			write_latch_out <= 1'b0;
			lock_reg_out <= `LOCK_RST;
			quad_lines_on_out <= `QUAD_RST;
		end else begin
			st <= next_st;
			plan <= next_plan;
			paused <= next_paused;
			field_cnt <= next_field_cnt;
			in_sr <= next_in_sr;
			opcode <= next_opcode;
			feat_addr <= next_feat_addr;
			wrap <= next_wrap;
			out_sr <= next_out_sr;
			out_pos <= next_out_pos;
			byte_idx <= next_byte_idx;
			io_o <= next_io_o;
			io_oe <= next_io_oe;
			cmd_valid_out <= next_cmd_valid;
			cmd_opcode_out <= next_cmd_op;
			cmd_addr_out <= next_cmd_addr;
			wr_data_valid_out <= next_wr_valid;
			wr_data_out <= next_wr_data;
			col_out <= next_col;
			write_latch_out <= next_latch;
			lock_reg_out <= next_lock;
			quad_lines_on_out <= next_quad;
		end
	end

	assign {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = io_o;
	assign {io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out, io_line_0_oe_out} = io_oe;

	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);

	sequence s_resume;
		paused ##1 !paused;
	endsequence

	a_latch_set: assert property (op_fin && op_byte == `OP_SET_LATCH |=> write_latch_out)
		else $error("write latch not set");
	a_latch_clear: assert property (op_fin && op_byte == `OP_CLR_LATCH |=> !write_latch_out)
		else $error("write latch not cleared");
	a_latch_done: assert property (op_done_in && !(op_fin && op_byte == `OP_SET_LATCH)
		|=> !write_latch_out)
		else $error("write latch kept after completion");
	a_exec_gated: assert property (cmd_valid_out && (cmd_opcode_out == `OP_PROG_EXEC ||
		cmd_opcode_out == `OP_BLK_ERASE) |-> $past(write_latch_out))
		else $error("program or erase issued without latch");
	a_pause_quiet: assert property (paused |-> io_oe == 4'h0)
		else $error("output driven while paused");
	a_pause_no_quad: assert property (quad_lines_on_out |-> !paused)
		else $error("pause active in quad mode");
	a_frame_end: assert property (cs_hi |=> st == nand_front_pkg::ST_OPCODE &&
		field_cnt == 6'd0 && io_oe == 4'h0)
		else $error("release did not end the frame");
	a_drive_fall: assert property ($rose(io_line_1_oe_out) |-> $past(fall))
		else $error("output enabled off a falling edge");
	a_resume_edge: assert property (s_resume |-> $past(resume_ev) || $past(cs_hi))
		else $error("pause left without falling edge");
	a_guard_keep: assert property (feat_wr && feat_addr == `FEAT_LOCK && guard_blk
		|=> $stable(lock_reg_out[5:1]))
		else $error("guarded lock bits changed");
	a_move_only: assert property (cmd_valid_out && (cmd_opcode_out == `OP_RLOAD ||
		cmd_opcode_out == `OP_RLOAD_QIO) |-> $past(move_active_in, 2) || $past(move_active_in))
		else $error("random load outside page move");

endmodule

// ==== serial_host_model.sv ====
// serial bus host that frames commands for the nand front end.
// assumes sys_clk_in at 100 MHz; serial period is 16 system cycles.
`timescale 1ns/1ns
module serial_host_model (
	input wire logic sys_clk_in,
	input wire logic [3:0] line_in,
	output logic sclk_out,
	output logic cs_n_out,
	output logic [3:0] line_out,
	output logic [3:0] line_oe_out
);
	localparam int HALF = 8; // half of a 160 ns serial period
	// idle: deselected, clock low, guard and pause pins high
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		line_out = 4'hc;
		line_oe_out = 4'hd;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// select stays low for the whole frame, pauses included
	task automatic frame(input logic sel);
		if (!sel) begin
			cs_n_out <= 1'b1;
			line_out <= 4'hc;
			line_oe_out <= 4'hd;
		end else begin
			cs_n_out <= 1'b0;
		end
		wait_clk(HALF);
		sclk_out <= 1'b0;
		wait_clk(HALF);
	endtask
	task automatic set_pin(input int idx, input logic val);
		line_out[idx] <= val;
		wait_clk(1);
	endtask
	// drive after the fall, sample just before the rise, msb first
	task automatic xfer(input logic [7:0] tx, input int lines, input int beats,
		input logic rd, output logic [7:0] rx);
		rx = 8'h00;
		for (int b = 0; b < beats; b++) begin
			sclk_out <= 1'b0;
			if (lines == 4) begin
				line_out <= tx[7-4*b -: 4];
				line_oe_out <= rd ? 4'h0 : 4'hf;
			end else if (lines == 2) begin
				// dual: line 1 carries the earlier bit, guard and pause stay high
				line_out[1:0] <= tx[7-2*b -: 2];
				line_oe_out <= rd ? 4'hc : 4'hf;
			end else begin
				line_out[0] <= tx[7-b];
			end
			wait_clk(HALF);
			rx = (lines == 4) ? {rx[3:0], line_in} :
				(lines == 2) ? {rx[5:0], line_in[1:0]} : {rx[6:0], line_in[1]};
			sclk_out <= 1'b1;
			wait_clk(HALF);
		end
	endtask
endmodule

// ==== test_nand_front_end.sv ====
// self-checking bench of the serial nand command front end.
// assumes the host model, header and design are compiled before it.
`timescale 1ns/1ns
`include "nand_front_regs.svh"
module test_nand_front_end;
	localparam logic [7:0] ID_MAKER = 8'h69; // arbitrary value
	localparam logic [7:0] ID_PART = 8'h96; // arbitrary value
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic op_done_in = 1'b0;
	logic move_active_in = 1'b0;
	logic busy = 1'b0; // status bit 0 seen by the front end
	logic [5:0] stat_hi = 6'h00; // upper status bits
	logic [7:0] lock_stat = 8'h3c; // answer of the block lock query
	logic flt = 1'b0; // pattern shown by undriven lines
	logic [3:0] h_out, h_oe, d_out, d_oe, lines;
	logic sclk, cs_n, write_latch, quad, cmd_valid, wr_valid;
	logic [7:0] opcode, wr_data, lock_reg, rx, last_wr;
	logic [23:0] cmd_addr;
	logic [11:0] col, last_col;
	int err_total = 0;
	int checks_done = 0;
	int n_cmd = 0;
	int exp_cmd = 0;
	initial forever #5 sys_clk_in = ~sys_clk_in;
	// a released line toggles so a stale bit never reads as good
	always @(posedge sys_clk_in) flt <= ~flt;
	assign lines = (h_oe & h_out) | (~h_oe & d_oe & d_out) | (~h_oe & ~d_oe & {4{flt}});
	// count accepted headers and keep the last loaded byte
	always @(posedge sys_clk_in) begin
		if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
		if (wr_valid === 1'b1) begin
			last_wr <= wr_data;
			last_col <= col - 12'd1;
		end
	end
	serial_host_model u_host (.sys_clk_in(sys_clk_in), .line_in(lines), .sclk_out(sclk),
		.cs_n_out(cs_n), .line_out(h_out), .line_oe_out(h_oe));
	nand_front_end #(.MAKER_CODE(ID_MAKER), .PART_CODE(ID_PART)) u_dut (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.io_line_0_in(lines[0]), .io_line_1_in(lines[1]), .io_line_2_in(lines[2]),
		.io_line_3_in(lines[3]), .io_line_0_out(d_out[0]), .io_line_1_out(d_out[1]),
		.io_line_2_out(d_out[2]), .io_line_3_out(d_out[3]), .io_line_0_oe_out(d_oe[0]),
		.io_line_1_oe_out(d_oe[1]), .io_line_2_oe_out(d_oe[2]), .io_line_3_oe_out(d_oe[3]),
		.rd_data_in(col[7:0] ^ 8'ha5), .lock_status_in(lock_stat), .status_hi_in(stat_hi),
		.busy_in(busy), .op_done_in(op_done_in), .move_active_in(move_active_in),
		.uid_in(64'h0123456789abcdef), .cmd_valid_out(cmd_valid), .cmd_opcode_out(opcode),
		.cmd_addr_out(cmd_addr), .wr_data_valid_out(wr_valid), .wr_data_out(wr_data),
		.col_out(col), .write_latch_out(write_latch), .lock_reg_out(lock_reg),
		.quad_lines_on_out(quad));
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// opcode then nb argument bytes, all on line 0
	task automatic send(input logic [7:0] op, input int nb, input logic [23:0] arg);
		u_host.frame(1'b1);
		u_host.xfer(op, 1, 8, 1'b0, rx);
		for (int i = 0; i < nb; i++) u_host.xfer(arg[8*(nb-1-i) +: 8], 1, 8, 1'b0, rx);
	endtask
	// end the frame; k headers should have been accepted in it
	task automatic stop(input int k);
		u_host.frame(1'b0);
		exp_cmd += k;
		check("header count", 24'(n_cmd), 24'(exp_cmd));
	endtask
	task automatic rd(input int n, input logic [7:0] exp);
		u_host.xfer(8'h00, n, 8 / n, 1'b1, rx);
		check("read byte", rx, exp);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		err_total++;
		close_out();
	end
	initial begin
		repeat (9) @(posedge sys_clk_in);
		#1 check("reset state", {write_latch, quad, lock_reg, d_oe}, 24'h0);
		@(posedge sys_clk_in);
		srst_in <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		u_host.frame(1'b1);
		u_host.xfer(`OP_SET_LATCH, 1, 4, 1'b0, rx);
		stop(0);
		send(`OP_PROG_EXEC, 3, 24'h000040);
		stop(0);
		send(`OP_SET_LATCH, 0, 24'h0);
		stop(1);
		check("latch set", {opcode, write_latch}, {8'h06, 1'b1});
		send(`OP_PROG_EXEC, 3, 24'h012345);
		stop(1);
		check("execute address", cmd_addr, 24'h012345);
		busy <= 1'b1;
		stat_hi <= 6'h2a;
		send(`OP_GET_FEAT, 1, 24'hc0);
		rd(1, 8'hab);
		stop(1);
		op_done_in <= 1'b1;
		@(posedge sys_clk_in);
		op_done_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		check("latch after done", write_latch, 24'h0);
		send(`OP_SET_LATCH, 0, 24'h0);
		stop(1);
		send(`OP_CLR_LATCH, 0, 24'h0);
		stop(1);
		check("latch cleared", write_latch, 24'h0);
		send(`OP_BLK_LOCK, 3, 24'hffffff);
		stop(1);
		check("lock address", cmd_addr, 24'h7ff000);
		send(`OP_RLOAD, 2, 24'h10);
		stop(0);
		move_active_in <= 1'b1;
		send(`OP_RLOAD, 2, 24'h10);
		stop(1);
		move_active_in <= 1'b0;
		send(`OP_SET_FEAT, 2, 24'ha0be);
		stop(1);
		u_host.set_pin(2, 1'b0);
		send(`OP_SET_FEAT, 2, 24'ha080);
		stop(1);
		check("guarded lock", lock_reg, 24'hbe);
		send(`OP_SET_FEAT, 2, 24'ha000);
		stop(1);
		check("open lock", lock_reg, 24'h00);
		send(`OP_LOAD, 2, 24'h0007);
		u_host.xfer(8'hc3, 1, 8, 1'b0, rx);
		stop(1);
		check("load byte", {last_col, last_wr}, {12'h007, 8'hc3});
		send(`OP_READ_ID, 1, 24'h0);
		rd(1, ID_MAKER);
		rd(1, ID_PART);
		stop(1);
		send(`OP_RD_CACHE, 3, 24'h000500);
		rd(1, 8'ha0);
		rd(1, 8'ha3);
		u_host.set_pin(3, 1'b0);
		u_host.xfer(8'h00, 1, 3, 1'b1, rx);
		check("paused", {d_oe[1], col}, {1'b0, 12'h007});
		u_host.set_pin(3, 1'b1);
		rd(1, 8'ha2);
		stop(1);
		check("released lines", d_oe, 24'h0);
		send(`OP_RD_CACHE, 3, 24'hc00f00);
		rd(1, 8'haa);
		rd(1, 8'ha5);
		stop(1);
		send(`OP_RD_CACHE_X2, 3, 24'h000500);
		rd(2, 8'ha0);
		stop(1);
		send(`OP_RD_CACHE_DIO, 0, 24'h0);
		for (int i = 0; i < 3; i++) u_host.xfer(i == 1 ? 8'h05 : 8'h00, 2, 4, 1'b0, rx);
		rd(2, 8'ha0);
		stop(1);
		send(`OP_READ_UID, 3, 24'h0);
		u_host.xfer(8'h00, 1, 8, 1'b0, rx);
		rd(1, 8'h01);
		rd(1, 8'h23);
		stop(1);
		lock_stat <= 8'h81;
		send(`OP_BLK_QUERY, 3, 24'h00f000);
		rd(1, 8'h81);
		stop(1);
		send(`OP_RD_CACHE_X4, 3, 24'h000500);
		stop(0);
		send(`OP_SET_FEAT, 2, 24'hb001);
		stop(1);
		check("quad on", quad, 24'h1);
		send(`OP_GET_FEAT, 1, 24'hb0);
		rd(1, 8'h01);
		stop(1);
		send(`OP_RD_CACHE_X4, 3, 24'h000500);
		rd(4, 8'ha0);
		stop(1);
		send(`OP_RD_CACHE_QIO, 0, 24'h0);
		for (int i = 0; i < 3; i++) u_host.xfer(i == 1 ? 8'h05 : 8'h00, 4, 2, 1'b0, rx);
		rd(4, 8'ha0);
		stop(1);
		close_out();
	end
endmodule
